// ==== volt_prot_pkg.sv ====
// Purpose: shared constants and carriers for the voltage protection stages
// Assumes: voltages arrive as whole percent of nominal, 8 bits wide
// Notes: register offsets are byte addresses on a 32-bit APB bus
package volt_prot_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam int DLY_W = 16;
    localparam int IRQ_W = 6;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OV_CFG = 8'h04;
    localparam logic [7:0] OFS_UV_CFG = 8'h08;
    localparam logic [7:0] OFS_RO_CFG = 8'h0C;
    localparam logic [7:0] OFS_OV_DLY = 8'h10;
    localparam logic [7:0] OFS_UV_DLY = 8'h14;
    localparam logic [7:0] OFS_RO_DLY = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    localparam logic [6:0] CTRL_RST = 7'h25;
    localparam logic [7:0] OV_PICK_RST = 8'h3F;
    localparam logic [7:0] UV_PICK_RST = 8'h5A;
    localparam logic [7:0] UV_BLOCK_RST = 8'h0A;
    localparam logic [7:0] RO_PICK_RST = 8'h1E;
    localparam logic [7:0] RATIO_RST = 8'h05;
    localparam logic [DLY_W-1:0] DELAY_RST = 16'h0064;

    typedef enum logic [1:0] {
        UV_OFF,
        UV_ONE_OF_3,
        UV_TWO_OF_3,
        UV_ALL
    } uv_mode_t;

    typedef struct packed {
        logic ro_so;
        logic ro_on;
        logic uv_so;
        uv_mode_t uv_mode;
        logic ov_so;
        logic ov_on;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] ratio;
        logic [7:0] pick;
    } thr_t;

    typedef struct packed {
        logic [7:0] res;
        logic [2:0][7:0] ph;
    } meas_t;

    typedef struct packed {
        logic ro_trip;
        logic ro_start;
        logic uv_trip;
        logic uv_start;
        logic [2:0] uv_ph;
        logic ov_trip;
        logic ov_start;
        logic [2:0] ov_ph;
    } prot_out_t;

endpackage

// ==== stage_delay_timer.sv ====
// Purpose: definite-time delay from a stage start to its trip
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes: the first millisecond may be short, since ticks are free running
`timescale 1ns/10ps
module stage_delay_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic start,
    input wire logic start_only,
    input wire logic [volt_prot_pkg::DLY_W-1:0] delay,
    output logic trip
);

    logic [volt_prot_pkg::DLY_W-1:0] cnt_ff;
    logic trip_ff;

    // saturate so a very long start cannot wrap to a short count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (!start) begin
            cnt_ff <= '0; // see R15
        end else if (tick && (cnt_ff != 16'hFFFF)) begin
            cnt_ff <= cnt_ff + 16'h0001; // see R6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_ff <= 1'b0;
        end else begin
            trip_ff <= start && !start_only && (cnt_ff >= delay); // see R5
        end
    end

    assign trip = trip_ff;

    property p_trip_after_delay;
        @(posedge pclk) disable iff (!presetn)
        $rose(trip_ff) |-> ($past(cnt_ff) >= $past(delay)) && $past(start);
    endproperty
    a_trip_after_delay: assert property (p_trip_after_delay) // see R6
        else $error("trip rose before the delay count was reached");

endmodule

// ==== voltage_protection_stages.sv ====
// Purpose: phase over/undervoltage and residual overvoltage stages with APB
// Assumes: measurement strobe and values synchronous to pclk
// Notes: hysteresis margin is in percent points of nominal voltage
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

// Behaviour
// R1: overvoltage start flag per phase whose voltage exceeds pick-up.
// R2: overvoltage general start while any phase is above pick-up.
// R3: over and undervoltage trip only after general start held for delay.
// R4: overvoltage and residual stages have On/Off, default On; Off gives nothing.
// R5: start-only selection, default off, keeps starts but blocks trip.
// R6: delay counted from start, 0 to 60000 ms, 1 ms steps, default 100.
// R7: reset ratio 1 to 10, default 5, releases start only past margin.
// R8: undervoltage phase start below pick-up (default 90) and above blocking.
// R9: undervoltage general start from phase starts per phase-count mode.
// R10: undervoltage modes Off, one, two or all of three; default one.
// R11: phases under blocking level (0 to 20, default 10) never start.
// R12: residual stage works on the residual voltage magnitude, 3U0.
// R13: residual start while above pick-up, 2 to 60, default 30.
// R14: residual trip after its start held for the delay.
// R15: millisecond tick drives delays; start loss clears counter and trip.
// R16: front end gives percent-scaled RMS values with a valid strobe.
module voltage_protection_stages #(
    parameter int unsigned TICK_CYCLES = volt_prot_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_valid,
    input wire volt_prot_pkg::meas_t meas,
    output volt_prot_pkg::prot_out_t prot,
    output logic irq
);

    function automatic logic over_hyst(input logic [7:0] v, input volt_prot_pkg::thr_t t,
                                       input logic prev);
        logic [8:0] up;
        up = {1'b0, v} + {1'b0, t.ratio};
        return (v > t.pick) || (prev && (up >= {1'b0, t.pick}));
    endfunction

    function automatic logic under_hyst(input logic [7:0] v, input volt_prot_pkg::thr_t t,
                                        input logic prev);
        logic [8:0] lim;
        lim = {1'b0, t.pick} + {1'b0, t.ratio};
        return (v < t.pick) || (prev && ({1'b0, v} <= lim));
    endfunction

    function automatic logic [1:0] ones3(input logic [2:0] b);
        return {1'b0, b[0]} + {1'b0, b[1]} + {1'b0, b[2]};
    endfunction

    volt_prot_pkg::ctrl_t ctrl_ff;
    volt_prot_pkg::thr_t ov_thr_ff;
    volt_prot_pkg::thr_t uv_thr_ff;
    volt_prot_pkg::thr_t ro_thr_ff;
    logic [7:0] uv_block_ff;
    logic [volt_prot_pkg::DLY_W-1:0] ov_dly_ff;
    logic [volt_prot_pkg::DLY_W-1:0] uv_dly_ff;
    logic [volt_prot_pkg::DLY_W-1:0] ro_dly_ff;
    logic [volt_prot_pkg::IRQ_W-1:0] stat_ff;
    logic [volt_prot_pkg::IRQ_W-1:0] mask_ff;
    logic irq_ff;
    volt_prot_pkg::meas_t meas_ff;
    volt_prot_pkg::prot_out_t prot_ff;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;

    logic [2:0] nxt_ov_ph;
    logic [2:0] nxt_uv_ph;
    logic nxt_ov;
    logic nxt_uv;
    logic nxt_ro;
    logic ov_trip_w;
    logic uv_trip_w;
    logic ro_trip_w;
    logic [volt_prot_pkg::IRQ_W-1:0] ev;
    logic [volt_prot_pkg::IRQ_W-1:0] clr;
    logic [31:0] rdata_c;
    logic hit_c;
    logic wr_en;

    // register bus: one wait state, answer registered
    assign wr_en = psel && penable && pready_ff && pwrite;

    always_comb begin
        rdata_c = 32'h0000_0000;
        hit_c = 1'b1;
        case (paddr)
            volt_prot_pkg::OFS_CTRL: rdata_c = {25'h0, ctrl_ff};
            volt_prot_pkg::OFS_OV_CFG: rdata_c = {16'h0, ov_thr_ff};
            volt_prot_pkg::OFS_UV_CFG: rdata_c = {8'h0, uv_block_ff, uv_thr_ff};
            volt_prot_pkg::OFS_RO_CFG: rdata_c = {16'h0, ro_thr_ff};
            volt_prot_pkg::OFS_OV_DLY: rdata_c = {16'h0, ov_dly_ff};
            volt_prot_pkg::OFS_UV_DLY: rdata_c = {16'h0, uv_dly_ff};
            volt_prot_pkg::OFS_RO_DLY: rdata_c = {16'h0, ro_dly_ff};
            volt_prot_pkg::OFS_STATUS: rdata_c = {20'h0, prot_ff};
            volt_prot_pkg::OFS_IRQ_STAT: rdata_c = {26'h0, stat_ff};
            volt_prot_pkg::OFS_IRQ_MASK: rdata_c = {26'h0, mask_ff};
            default: hit_c = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            if (psel && penable && !pready_ff) begin
                pslverr_ff <= !hit_c;
                prdata_ff <= pwrite ? 32'h0000_0000 : rdata_c;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // settings; values outside the documented ranges are taken as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= volt_prot_pkg::ctrl_t'(volt_prot_pkg::CTRL_RST); // see R4
            ov_thr_ff <= {volt_prot_pkg::RATIO_RST, volt_prot_pkg::OV_PICK_RST}; // see R7
            uv_thr_ff <= {volt_prot_pkg::RATIO_RST, volt_prot_pkg::UV_PICK_RST};
            ro_thr_ff <= {volt_prot_pkg::RATIO_RST, volt_prot_pkg::RO_PICK_RST};
            uv_block_ff <= volt_prot_pkg::UV_BLOCK_RST; // see R11
            ov_dly_ff <= volt_prot_pkg::DELAY_RST; // see R6
            uv_dly_ff <= volt_prot_pkg::DELAY_RST;
            ro_dly_ff <= volt_prot_pkg::DELAY_RST;
            mask_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                volt_prot_pkg::OFS_CTRL: ctrl_ff <= volt_prot_pkg::ctrl_t'(pwdata[6:0]);
                volt_prot_pkg::OFS_OV_CFG: ov_thr_ff <= pwdata[15:0];
                volt_prot_pkg::OFS_UV_CFG: begin
                    uv_thr_ff <= pwdata[15:0];
                    uv_block_ff <= pwdata[23:16];
                end
                volt_prot_pkg::OFS_RO_CFG: ro_thr_ff <= pwdata[15:0];
                volt_prot_pkg::OFS_OV_DLY: ov_dly_ff <= pwdata[15:0];
                volt_prot_pkg::OFS_UV_DLY: uv_dly_ff <= pwdata[15:0];
                volt_prot_pkg::OFS_RO_DLY: ro_dly_ff <= pwdata[15:0];
                volt_prot_pkg::OFS_IRQ_MASK: mask_ff <= pwdata[volt_prot_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // hold the last strobed values; stages act on these between updates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_ff <= '0;
        end else if (meas_valid) begin
            meas_ff <= meas; // see R16
        end
    end

    // free-running millisecond tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1; // see R15
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_ov_ph[i] = ctrl_ff.ov_on
                && over_hyst(meas_ff.ph[i], ov_thr_ff, prot_ff.ov_ph[i]); // see R1
            // a dead phase (open breaker) must not look like an undervoltage
            nxt_uv_ph[i] = (ctrl_ff.uv_mode != volt_prot_pkg::UV_OFF)
                && (meas_ff.ph[i] >= uv_block_ff) // see R11
                && under_hyst(meas_ff.ph[i], uv_thr_ff, prot_ff.uv_ph[i]); // see R8
        end
        nxt_ov = |nxt_ov_ph; // see R2
        case (ctrl_ff.uv_mode)
            volt_prot_pkg::UV_ONE_OF_3: nxt_uv = ones3(nxt_uv_ph) >= 2'h1; // see R9
            volt_prot_pkg::UV_TWO_OF_3: nxt_uv = ones3(nxt_uv_ph) >= 2'h2; // see R10
            volt_prot_pkg::UV_ALL: nxt_uv = ones3(nxt_uv_ph) == 2'h3;
            default: nxt_uv = 1'b0;
        endcase
        // residual input is already 3U0 from the front end
        nxt_ro = ctrl_ff.ro_on
            && over_hyst(meas_ff.res, ro_thr_ff, prot_ff.ro_start); // see R12 R13
    end

    stage_delay_timer ov_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_ff),
        .start(prot_ff.ov_start),
        .start_only(ctrl_ff.ov_so),
        .delay(ov_dly_ff),
        .trip(ov_trip_w)
    ); // see R3

    stage_delay_timer uv_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_ff),
        .start(prot_ff.uv_start),
        .start_only(ctrl_ff.uv_so),
        .delay(uv_dly_ff),
        .trip(uv_trip_w)
    ); // see R3

    stage_delay_timer ro_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_ff),
        .start(prot_ff.ro_start),
        .start_only(ctrl_ff.ro_so),
        .delay(ro_dly_ff),
        .trip(ro_trip_w)
    ); // see R14

    // trips lag their timer by one cycle so every output leaves a flop here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_ff <= '0;
        end else begin
            prot_ff.ov_ph <= nxt_ov_ph;
            prot_ff.ov_start <= nxt_ov;
            prot_ff.ov_trip <= ov_trip_w; // see R5
            prot_ff.uv_ph <= nxt_uv_ph;
            prot_ff.uv_start <= nxt_uv;
            prot_ff.uv_trip <= uv_trip_w;
            prot_ff.ro_start <= nxt_ro;
            prot_ff.ro_trip <= ro_trip_w;
        end
    end

    // rising edges of starts and trips; a set in the clear cycle wins
    assign ev = {ro_trip_w & ~prot_ff.ro_trip, nxt_ro & ~prot_ff.ro_start,
                 uv_trip_w & ~prot_ff.uv_trip, nxt_uv & ~prot_ff.uv_start,
                 ov_trip_w & ~prot_ff.ov_trip, nxt_ov & ~prot_ff.ov_start};
    assign clr = (wr_en && (paddr == volt_prot_pkg::OFS_IRQ_STAT))
        ? pwdata[volt_prot_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prot = prot_ff;
    assign irq = irq_ff;

    property p_ov_phase;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_ff.ov_on && (meas_ff.ph[0] > ov_thr_ff.pick)) |=> prot_ff.ov_ph[0];
    endproperty
    a_ov_phase: assert property (p_ov_phase) // see R1
        else $error("overvoltage phase start missing");

    property p_ov_general;
        @(posedge pclk) disable iff (!presetn)
        prot_ff.ov_start == (|prot_ff.ov_ph);
    endproperty
    a_ov_general: assert property (p_ov_general) // see R2
        else $error("overvoltage general start disagrees with phases");

    property p_uv_trip_held;
        @(posedge pclk) disable iff (!presetn)
        $rose(prot_ff.uv_trip) |-> $past(prot_ff.uv_start, 2);
    endproperty
    a_uv_trip_held: assert property (p_uv_trip_held) // see R3
        else $error("undervoltage trip without held start");

    property p_ov_off;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.ov_on)[*4] |-> !prot_ff.ov_start && !prot_ff.ov_trip;
    endproperty
    a_ov_off: assert property (p_ov_off) // see R4
        else $error("overvoltage stage active while off");

    property p_ro_start_only;
        @(posedge pclk) disable iff (!presetn)
        ctrl_ff.ro_so[*3] |-> !prot_ff.ro_trip;
    endproperty
    a_ro_start_only: assert property (p_ro_start_only) // see R5
        else $error("residual trip while start-only");

    property p_ov_hold;
        @(posedge pclk) disable iff (!presetn)
        (prot_ff.ov_ph[1] && ctrl_ff.ov_on
            && (({1'b0, meas_ff.ph[1]} + {1'b0, ov_thr_ff.ratio}) >= {1'b0, ov_thr_ff.pick}))
        |=> prot_ff.ov_ph[1];
    endproperty
    a_ov_hold: assert property (p_ov_hold) // see R7
        else $error("overvoltage start released inside the margin");

    property p_uv_block;
        @(posedge pclk) disable iff (!presetn)
        (meas_ff.ph[2] < uv_block_ff) |=> !prot_ff.uv_ph[2];
    endproperty
    a_uv_block: assert property (p_uv_block) // see R11
        else $error("undervoltage start on a blocked phase");

    property p_uv_all;
        @(posedge pclk) disable iff (!presetn)
        (prot_ff.uv_start && $past(ctrl_ff.uv_mode) == volt_prot_pkg::UV_ALL)
        |-> (&prot_ff.uv_ph);
    endproperty
    a_uv_all: assert property (p_uv_all) // see R10
        else $error("undervoltage all-phase mode started with a phase missing");

    property p_ro_start;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_ff.ro_on && (meas_ff.res > ro_thr_ff.pick)) |=> prot_ff.ro_start;
    endproperty
    a_ro_start: assert property (p_ro_start) // see R13
        else $error("residual start missing");

    property p_ro_trip_held;
        @(posedge pclk) disable iff (!presetn)
        $rose(prot_ff.ro_trip) |-> $past(prot_ff.ro_start, 2);
    endproperty
    a_ro_trip_held: assert property (p_ro_trip_held) // see R14
        else $error("residual trip without held start");

    property p_ov_clear;
        @(posedge pclk) disable iff (!presetn)
        !prot_ff.ov_start |-> ##2 !prot_ff.ov_trip;
    endproperty
    a_ov_clear: assert property (p_ov_clear) // see R15
        else $error("overvoltage trip outlived its start");

endmodule

// ==== meas_source.sv ====
// Purpose: measurement front end model feeding percent-scaled RMS values
// Assumes: one strobe cycle per update, values in whole percent of nominal
// Notes: data is inverted outside the strobe so stale values are never trusted
`timescale 1ns/10ps
module meas_source (
    input wire logic pclk,
    output logic meas_valid,
    output volt_prot_pkg::meas_t meas
);
    initial begin
        meas_valid = 1'b0;
        meas = '0;
    end

    task automatic send(input logic [7:0] p0, input logic [7:0] p1,
                        input logic [7:0] p2, input logic [7:0] r);
        @(posedge pclk);
        meas_valid <= 1'b1;
        meas <= {r, p2, p1, p0};
        @(posedge pclk);
        meas_valid <= 1'b0;
        meas <= ~{r, p2, p1, p0};
    endtask
endmodule

// ==== test_voltage_protection_stages.sv ====
// Purpose: self-checking bench for the voltage protection stages
// Assumes: short millisecond tick of 4 cycles to keep delays brief
// Notes: APB master waits on pready under a bound
`timescale 1ns/10ps
module test_voltage_protection_stages;
    localparam int unsigned TCK = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic ev;
    volt_prot_pkg::meas_t meas;
    volt_prot_pkg::prot_out_t prot;
    int n_mismatch, samples_checked;

    voltage_protection_stages #(.TICK_CYCLES(TCK)) voltage_protection_stages_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
        .meas(meas), .prot(prot), .irq(irq));
    meas_source meas_source_inst (.pclk(pclk), .meas_valid(meas_valid), .meas(meas));

    always #25 pclk = ~pclk;

    task automatic conclude;
        $display("counts: mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_mismatch++;
            conclude();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk({31'h0, ev}, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask

    task automatic t_defaults;
        rd(volt_prot_pkg::OFS_CTRL, 32'h25);
        rd(volt_prot_pkg::OFS_OV_CFG, 32'h053F);
        rd(volt_prot_pkg::OFS_UV_CFG, 32'h000A055A);
        rd(volt_prot_pkg::OFS_RO_CFG, 32'h051E);
        rd(volt_prot_pkg::OFS_OV_DLY, 32'h64);
        rd(volt_prot_pkg::OFS_UV_DLY, 32'h64);
        rd(volt_prot_pkg::OFS_RO_DLY, 32'h64);
        rd(volt_prot_pkg::OFS_IRQ_MASK, 32'h0);
        rd(volt_prot_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, ev}, 32'h1);
        $display("test defaults done");
    endtask

    task automatic t_ov;
        int i;
        wr(volt_prot_pkg::OFS_OV_DLY, 32'h3);
        wr(volt_prot_pkg::OFS_IRQ_MASK, 32'h1);
        // pick-up above nominal so healthy phases stay quiet
        wr(volt_prot_pkg::OFS_OV_CFG, 32'h056E);
        meas_source_inst.send(8'd100, 8'd120, 8'd100, 8'd0);
        settle();
        chk({29'h0, prot.ov_ph}, 32'h2);
        chk({30'h0, prot.ov_start, prot.ov_trip}, 32'h2);
        chk({31'h0, irq}, 32'h1);
        i = 0;
        while (prot.ov_trip !== 1'b1 && i < 40) begin
            @(posedge pclk);
            i++;
        end
        chk({31'h0, (i < 20)}, 32'h1);
        // margin keeps start: 106 + 5 is not below 110
        meas_source_inst.send(8'd100, 8'd106, 8'd100, 8'd0);
        settle();
        chk({31'h0, prot.ov_start}, 32'h1);
        meas_source_inst.send(8'd100, 8'd104, 8'd100, 8'd0);
        settle();
        chk({27'h0, prot.ov_trip, prot.ov_start, prot.ov_ph}, 32'h0);
        rd(volt_prot_pkg::OFS_IRQ_STAT, 32'h3);
        wr(volt_prot_pkg::OFS_IRQ_STAT, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h0);
        rd(volt_prot_pkg::OFS_IRQ_STAT, 32'h2);
        wr(volt_prot_pkg::OFS_IRQ_STAT, 32'h3F);
        wr(volt_prot_pkg::OFS_IRQ_MASK, 32'h0);
        wr(volt_prot_pkg::OFS_CTRL, 32'h24);
        meas_source_inst.send(8'd100, 8'd130, 8'd100, 8'd0);
        settle();
        chk({27'h0, prot.ov_trip, prot.ov_start, prot.ov_ph}, 32'h0);
        meas_source_inst.send(8'd100, 8'd100, 8'd100, 8'd0);
        wr(volt_prot_pkg::OFS_CTRL, 32'h25);
        $display("test overvoltage done");
    endtask

    task automatic t_uv;
        logic [3:0] exp_st;
        exp_st = 4'b0110;
        wr(volt_prot_pkg::OFS_UV_DLY, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(volt_prot_pkg::OFS_CTRL, 32'h21 | (m << 2));
            meas_source_inst.send(8'd50, 8'd50, 8'd100, 8'd0);
            settle();
            settle();
            chk({29'h0, prot.uv_ph}, (m == 0) ? 32'h0 : 32'h3);
            chk({30'h0, prot.uv_start, prot.uv_trip}, {30'h0, {2{exp_st[m]}}});
        end
        // a phase under the block level must not count toward two of three
        wr(volt_prot_pkg::OFS_CTRL, 32'h29);
        meas_source_inst.send(8'd50, 8'd5, 8'd100, 8'd0);
        settle();
        chk({29'h0, prot.uv_ph}, 32'h1);
        chk({31'h0, prot.uv_start}, 32'h0);
        meas_source_inst.send(8'd100, 8'd100, 8'd100, 8'd0);
        wr(volt_prot_pkg::OFS_CTRL, 32'h25);
        $display("test undervoltage done");
    endtask

    task automatic t_ro;
        // drop the undervoltage events left by the previous test
        wr(volt_prot_pkg::OFS_IRQ_STAT, 32'h3F);
        wr(volt_prot_pkg::OFS_RO_DLY, 32'h1);
        meas_source_inst.send(8'd100, 8'd100, 8'd100, 8'd40);
        repeat (20) @(posedge pclk);
        chk({30'h0, prot.ro_start, prot.ro_trip}, 32'h3);
        chk({31'h0, irq}, 32'h0);
        rd(volt_prot_pkg::OFS_IRQ_STAT, 32'h30);
        wr(volt_prot_pkg::OFS_CTRL, 32'h65);
        meas_source_inst.send(8'd100, 8'd100, 8'd100, 8'd41);
        repeat (20) @(posedge pclk);
        chk({30'h0, prot.ro_start, prot.ro_trip}, 32'h2);
        rd(volt_prot_pkg::OFS_STATUS, 32'h400);
        wr(volt_prot_pkg::OFS_CTRL, 32'h05);
        settle();
        chk({30'h0, prot.ro_start, prot.ro_trip}, 32'h0);
        $display("test residual done");
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_defaults();
        t_ov();
        t_uv();
        t_ro();
        conclude();
    end
endmodule
